/* rtl/ftc_frame_ctrl.sv */
// Functional notes
// - auto-append FCS when append bit set
// - transmit accepted only in prepare state
// - prepare from off tunes, powers, ready irq
// - ramp, preamble and header, then buffer
// - after tail and down-ramp, end irq, prepare
// - receive command enters receive state
// - preamble holds gain; header raises start irq
// - address irq only with enabled filter match
// - good FCS raises end irq, goes prepare
// - bad frame stays receive, releases gain
// - expose rx length, buffer, auto energy
// - auto mode measures, compares, sends if idle
// - idle result updates status, ready, transmit
// - busy result stays in receive
// - auto transmit re-enables baseband itself
// - end irq when auto send ends or result is busy; a run dropped by a state command raises none
`timescale 1ns/1ps
`include "ftc_map.svh"
module ftc_frame_ctrl #(
	parameter int LEN_W = 11,
	parameter int BUF_DEPTH = 2048
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// receive events from demodulator
	input wire ftc_pkg::ftc_rx_ev_t rx_ev,
	input wire logic [7:0] rx_data,
	input wire logic rx_data_valid,
	// transmit octet stream
	output ftc_pkg::ftc_tx_oct_t tx_oct,
	output logic pa_on,
	// analog and status
	output logic analog_supply,
	output logic agc_hold,
	output logic baseband_enable,
	output logic ed_start
);
	ftc_pkg::ftc_state_t state;
	ftc_pkg::ftc_state_t next_state;
	logic [7:0] ctrl;
	logic [7:0] amcs;
	logic [7:0] thr;
	logic [7:0] edv;
	logic [7:0] irqs;
	logic [LEN_W-1:0] tx_len;
	logic [LEN_W-1:0] rx_len;
	logic [15:0] cnt;
	logic [LEN_W-1:0] tx_idx;
	logic [LEN_W-1:0] rx_idx;
	logic [LEN_W-1:0] rd_idx;
	logic [LEN_W-1:0] tx_wr_idx;
	logic auto_run;
	logic bb_auto;
	logic [7:0] tx_buf [BUF_DEPTH];
	logic [7:0] rx_buf [BUF_DEPTH];
	logic [7:0] irq_set;
	logic [15:0] crc;
	logic [LEN_W-1:0] payload_len;
	logic cmd_wr;
	logic idle_ch;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	assign cmd_wr = reg_wr && reg_addr == `FTC_A_CMD;
	assign idle_ch = rx_ev.ed_value < thr;
	assign payload_len = ctrl[`FTC_CTRL_AFCS] ? tx_len - (ctrl[`FTC_CTRL_FCST] ? LEN_W'(`FTC_FCS2) : LEN_W'(`FTC_FCS4))
		: tx_len;

	// state transitions
	always_comb
	begin
		next_state = state;
		case (state)
			ftc_pkg::ST_OFF:
			begin
				if (cmd_wr && reg_wdata[2:0] == `FTC_CMD_PREP)
					next_state = ftc_pkg::ST_PREP_WAIT;
				else if (cmd_wr && reg_wdata[2:0] == `FTC_CMD_RX)
					next_state = ftc_pkg::ST_RX;
			end
			ftc_pkg::ST_PREP_WAIT:
			begin
				if (cnt == `FTC_PREP_CYC)
					next_state = ftc_pkg::ST_PREP;
			end
			ftc_pkg::ST_PREP:
			begin
				if (cmd_wr && reg_wdata[2:0] == `FTC_CMD_TX)
					next_state = ftc_pkg::ST_TX_RAMP;
				else if (cmd_wr && reg_wdata[2:0] == `FTC_CMD_RX)
					next_state = ftc_pkg::ST_RX;
				else if (cmd_wr && reg_wdata[2:0] == `FTC_CMD_OFF)
					next_state = ftc_pkg::ST_OFF;
			end
			ftc_pkg::ST_RX:
			begin
				if (auto_run && rx_ev.ed_done && idle_ch)
					next_state = ftc_pkg::ST_TX_RAMP;
				else if (baseband_enable && rx_ev.frame_end && rx_ev.fcs_ok)
					next_state = ftc_pkg::ST_PREP;
				else if (cmd_wr && reg_wdata[2:0] == `FTC_CMD_PREP)
					next_state = ftc_pkg::ST_PREP;
				else if (cmd_wr && reg_wdata[2:0] == `FTC_CMD_OFF)
					next_state = ftc_pkg::ST_OFF;
			end
			ftc_pkg::ST_TX_RAMP:
			begin
				if (cnt == `FTC_RAMP_CYC)
					next_state = ftc_pkg::ST_TX_SHR;
			end
			ftc_pkg::ST_TX_SHR:
			begin
				if (cnt == `FTC_SHR_CYC)
					next_state = ftc_pkg::ST_TX_DATA;
			end
			ftc_pkg::ST_TX_DATA:
			begin
				if (tx_idx == tx_len)
					next_state = ftc_pkg::ST_TX_DOWN;
			end
			ftc_pkg::ST_TX_DOWN:
			begin
				if (cnt == `FTC_RAMP_CYC)
					next_state = ftc_pkg::ST_PREP;
			end
			default: next_state = ftc_pkg::ST_OFF;
		endcase
	end

	// commands in other states fall through unchanged
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			state <= ftc_pkg::ST_OFF;
		else
			state <= next_state;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cnt <= 16'h0000;
		else if (next_state != state)
			cnt <= 16'h0000;
		else
			cnt <= cnt + 16'h0001;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			analog_supply <= 1'b0;
		else
			analog_supply <= next_state != ftc_pkg::ST_OFF;
	end

	// transmit octet sequencing with appended checksum
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_idx <= '0;
			crc <= 16'h0000;
			tx_oct <= '0;
			pa_on <= 1'b0;
		end
		else
		begin
			pa_on <= next_state inside {ftc_pkg::ST_TX_RAMP, ftc_pkg::ST_TX_SHR, ftc_pkg::ST_TX_DATA};
			tx_oct.valid <= 1'b0;
			tx_oct.fcs <= 1'b0;
			if (state != ftc_pkg::ST_TX_DATA)
			begin
				tx_idx <= '0;
				crc <= 16'h0000;
			end
			else if (tx_idx != tx_len)
			begin
				tx_idx <= tx_idx + LEN_W'(1);
				tx_oct.valid <= 1'b1;
				if (tx_idx < payload_len)
				begin
					tx_oct.data <= tx_buf[tx_idx];
					crc <= crc_step(crc, tx_buf[tx_idx]);
				end
				else
				begin
					tx_oct.fcs <= 1'b1;
					tx_oct.data <= tx_idx[0] == payload_len[0] ? crc[7:0] : crc[15:8];
				end
			end
		end
	end

	// auto clear-channel transmit run flag and baseband control
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			auto_run <= 1'b0;
			bb_auto <= 1'b0;
		end
		else
		begin
			bb_auto <= 1'b0;
			if (state == ftc_pkg::ST_RX && amcs[`FTC_AUTO_CCA_TRANSMIT_ENABLE] && reg_wr && reg_addr == `FTC_A_EDC
				&& reg_wdata[1:0] == 2'h1)
				auto_run <= 1'b1;
			else if (auto_run && rx_ev.ed_done && !idle_ch)
				auto_run <= 1'b0;
			else if (auto_run && state == ftc_pkg::ST_TX_RAMP)
			begin
				auto_run <= 1'b0;
				bb_auto <= 1'b1;
			end
			// a run left by a state command must not re-enable a later manual send
			else if (auto_run && state != ftc_pkg::ST_RX)
				auto_run <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			ctrl <= `FTC_CTRL_RST;
		else
		begin
			if (reg_wr && reg_addr == `FTC_A_CTRL)
				ctrl <= reg_wdata;
			// hardware enable wins over a host write in the same cycle
			if (bb_auto)
				ctrl[`FTC_CTRL_BBEN] <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			baseband_enable <= 1'b0;
		else
			baseband_enable <= bb_auto | (reg_wr && reg_addr == `FTC_A_CTRL ? reg_wdata[`FTC_CTRL_BBEN]
				: ctrl[`FTC_CTRL_BBEN]);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			amcs <= 8'h00;
		else
		begin
			if (reg_wr && reg_addr == `FTC_A_AMCS)
				amcs[2:0] <= reg_wdata[2:0];
			// compare status is read-only and never lost to a host write
			if (auto_run && rx_ev.ed_done)
				amcs[`FTC_CCA_COMPARE_STATUS] <= !idle_ch;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			thr <= `FTC_THR_RST;
		else if (reg_wr && reg_addr == `FTC_A_THR)
			thr <= reg_wdata;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			tx_len <= '0;
		else if (reg_wr && reg_addr == `FTC_A_TXLL)
			tx_len[7:0] <= reg_wdata;
		else if (reg_wr && reg_addr == `FTC_A_TXLH)
			tx_len[LEN_W-1:8] <= reg_wdata[LEN_W-9:0];
	end

	// transmit buffer fill: write pointer resets on length low write
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			tx_wr_idx <= '0;
		else if (reg_wr && reg_addr == `FTC_A_TXLL)
			tx_wr_idx <= '0;
		else if (reg_wr && reg_addr == `FTC_A_TXBUF)
			tx_wr_idx <= tx_wr_idx + LEN_W'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (reg_wr && reg_addr == `FTC_A_TXBUF)
			tx_buf[tx_wr_idx] <= reg_wdata;
		if (state == ftc_pkg::ST_RX && rx_data_valid)
			rx_buf[rx_idx] <= rx_data;
	end

	// receive path: gain hold, length capture, energy at frame start
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			agc_hold <= 1'b0;
			rx_idx <= '0;
			rx_len <= '0;
			edv <= 8'h00;
			ed_start <= 1'b0;
		end
		else
		begin
			ed_start <= (state == ftc_pkg::ST_RX && baseband_enable && rx_ev.header_ok)
				|| (reg_wr && reg_addr == `FTC_A_EDC && reg_wdata[1:0] == 2'h1);
			if (rx_ev.ed_done)
				edv <= rx_ev.ed_value;
			if (state != ftc_pkg::ST_RX || rx_ev.frame_end)
				agc_hold <= 1'b0;
			else if (baseband_enable && rx_ev.preamble)
				agc_hold <= 1'b1;
			if (state == ftc_pkg::ST_RX && rx_ev.header_ok)
				rx_idx <= '0;
			else if (state == ftc_pkg::ST_RX && rx_data_valid)
				rx_idx <= rx_idx + LEN_W'(1);
			if (state == ftc_pkg::ST_RX && baseband_enable && rx_ev.frame_end && rx_ev.fcs_ok)
				rx_len <= rx_ev.length;
		end
	end

	always_comb
	begin
		irq_set = 8'h00;
		irq_set[`FTC_IRQ_TRANSCEIVER_READY_IRQ] = next_state == ftc_pkg::ST_PREP && state != ftc_pkg::ST_PREP
			|| (state == ftc_pkg::ST_RX && next_state == ftc_pkg::ST_TX_RAMP);
		irq_set[`FTC_IRQ_TXFE] = (state == ftc_pkg::ST_TX_DOWN && next_state == ftc_pkg::ST_PREP)
			|| (auto_run && rx_ev.ed_done && !idle_ch);
		irq_set[`FTC_IRQ_RXFS] = state == ftc_pkg::ST_RX && baseband_enable && rx_ev.header_ok;
		irq_set[`FTC_IRQ_RXAM] = state == ftc_pkg::ST_RX && baseband_enable && ctrl[`FTC_CTRL_FILT]
			&& rx_ev.addr_match;
		irq_set[`FTC_IRQ_RXFE] = state == ftc_pkg::ST_RX && baseband_enable && rx_ev.frame_end
			&& rx_ev.fcs_ok;
		irq_set[`FTC_IRQ_EDC] = rx_ev.ed_done;
	end

	// status clears on read; a same-cycle event wins
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			irqs <= 8'h00;
		else if (reg_rd && reg_addr == `FTC_A_IRQS)
			irqs <= irq_set;
		else
			irqs <= irqs | irq_set;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			rd_idx <= '0;
		else if (reg_rd && reg_addr == `FTC_A_RXBS)
			rd_idx <= rd_idx + LEN_W'(1);
		else if (irq_set[`FTC_IRQ_RXFE])
			rd_idx <= '0;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`FTC_A_CTRL: reg_rdata <= ctrl;
				`FTC_A_AMCS: reg_rdata <= amcs;
				`FTC_A_THR: reg_rdata <= thr;
				`FTC_A_TXLL: reg_rdata <= tx_len[7:0];
				`FTC_A_TXLH: reg_rdata <= 8'(tx_len[LEN_W-1:8]);
				`FTC_A_RXLL: reg_rdata <= rx_len[7:0];
				`FTC_A_RXLH: reg_rdata <= 8'(rx_len[LEN_W-1:8]);
				`FTC_A_EDV: reg_rdata <= edv;
				`FTC_A_IRQS: reg_rdata <= irqs;
				`FTC_A_STATE: reg_rdata <= 8'(state);
				`FTC_A_RXBS: reg_rdata <= rx_buf[rd_idx];
				default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end
endmodule : ftc_frame_ctrl

/* rtl/ftc_map.svh */
`ifndef FTC_MAP_SVH
`define FTC_MAP_SVH
// register addresses (8-bit index)
`define FTC_A_CMD 8'h00
`define FTC_A_CTRL 8'h01
`define FTC_A_AMCS 8'h02
`define FTC_A_EDC 8'h03
`define FTC_A_THR 8'h04
`define FTC_A_TXLL 8'h05
`define FTC_A_TXLH 8'h06
`define FTC_A_RXLL 8'h07
`define FTC_A_RXLH 8'h08
`define FTC_A_EDV 8'h09
`define FTC_A_IRQS 8'h0A
`define FTC_A_STATE 8'h0B
`define FTC_A_RXBS 8'h0C
`define FTC_A_TXBUF 8'h0D
// command codes
`define FTC_CMD_OFF 3'h0
`define FTC_CMD_PREP 3'h1
`define FTC_CMD_TX 3'h2
`define FTC_CMD_RX 3'h3
// control register bits, then auto mode control and status bits
`define FTC_CTRL_BBEN 0
`define FTC_CTRL_AFCS 1
`define FTC_CTRL_FCST 2
`define FTC_CTRL_FILT 3
`define FTC_AUTO_CCA_TRANSMIT_ENABLE 0
`define FTC_AUTO_ACK_ENABLE 1
`define FTC_TX_THEN_RX_ENABLE 2
`define FTC_CCA_COMPARE_STATUS 3
// irq status bits
`define FTC_IRQ_TRANSCEIVER_READY_IRQ 0
`define FTC_IRQ_TXFE 1
`define FTC_IRQ_RXFS 2
`define FTC_IRQ_RXAM 3
`define FTC_IRQ_RXFE 4
`define FTC_IRQ_EDC 5
// reset values
`define FTC_CTRL_RST 8'h03
`define FTC_THR_RST 8'h00
// timing in cycles; checksum lengths in octets
`define FTC_PREP_CYC 16'h0010
`define FTC_RAMP_CYC 16'h0004
`define FTC_SHR_CYC 16'h0008
`define FTC_FCS2 16'h0002
`define FTC_FCS4 16'h0004
`endif

/* rtl/ftc_pkg.sv */
package ftc_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_PREP_WAIT, ST_PREP, ST_RX, ST_TX_RAMP, ST_TX_SHR, ST_TX_DATA, ST_TX_DOWN}
		ftc_state_t;
	typedef struct packed {
		logic preamble;
		logic header_ok;
		logic addr_match;
		logic frame_end;
		logic fcs_ok;
		logic ed_done;
		logic [7:0] ed_value;
		logic [10:0] length;
	} ftc_rx_ev_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic fcs;
	} ftc_tx_oct_t;
endpackage : ftc_pkg

/* verif/ftc_frame_ctrl_monitor.sv */
`timescale 1ns/1ps
module ftc_frame_ctrl_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// watched ports
	input wire ftc_pkg::ftc_rx_ev_t rx_ev,
	input wire ftc_pkg::ftc_tx_oct_t tx_oct,
	input wire logic pa_on,
	input wire logic analog_supply,
	input wire logic agc_hold,
	input wire logic baseband_enable,
	input wire logic ed_start
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	property p_supply;
		pa_on |-> analog_supply;
	endproperty
	a_supply: assert property (p_supply) else $error("amplifier on without supply");
	property p_ramp;
		$rose(pa_on) |-> !tx_oct.valid [*8];
	endproperty
	a_ramp: assert property (p_ramp) else $error("octet during ramp or preamble");
	property p_oct_pa;
		tx_oct.valid |-> pa_on || $past(pa_on);
	endproperty
	a_oct_pa: assert property (p_oct_pa) else $error("octet with amplifier off");
	property p_fcs_last;
		tx_oct.valid && tx_oct.fcs |=> !tx_oct.valid || tx_oct.fcs;
	endproperty
	a_fcs_last: assert property (p_fcs_last) else $error("payload after checksum");
	property p_agc_hold;
		rx_ev.preamble |=> ##[0:1] agc_hold;
	endproperty
	a_agc_hold: assert property (p_agc_hold) else $error("gain not held");
	property p_agc_free;
		rx_ev.frame_end && !rx_ev.fcs_ok |=> ##[0:2] !agc_hold;
	endproperty
	a_agc_free: assert property (p_agc_free) else $error("gain not released");
	property p_ed_start;
		rx_ev.header_ok && agc_hold |=> ##[0:1] ed_start;
	endproperty
	a_ed_start: assert property (p_ed_start) else $error("no energy start at frame start");
	property p_bb_tx;
		pa_on && $past(pa_on, 2) |-> baseband_enable;
	endproperty
	a_bb_tx: assert property (p_bb_tx) else $error("baseband off while sending");
endmodule : ftc_frame_ctrl_monitor

bind ftc_frame_ctrl ftc_frame_ctrl_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .rx_ev(rx_ev),
	.tx_oct(tx_oct), .pa_on(pa_on), .analog_supply(analog_supply), .agc_hold(agc_hold),
	.baseband_enable(baseband_enable), .ed_start(ed_start));

/* verif/ftc_radio_model.sv */
`timescale 1ns/1ps
module ftc_radio_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// air side
	input wire ftc_pkg::ftc_tx_oct_t tx_oct,
	output ftc_pkg::ftc_rx_ev_t rx_ev,
	output logic [7:0] rx_data,
	output logic rx_data_valid,
	output logic [7:0] fcs_cnt
);
	initial
	begin
		rx_ev = '0;
		rx_data = 8'h00;
		rx_data_valid = 1'b0;
	end
	// counts appended checksum octets on air
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			fcs_cnt <= 8'h00;
		else if (tx_oct.valid && tx_oct.fcs)
			fcs_cnt <= fcs_cnt + 8'h01;
	task automatic step(input ftc_pkg::ftc_rx_ev_t e, input logic dv, input logic [7:0] d);
		@(posedge core_clk);
		rx_ev <= e;
		rx_data_valid <= dv;
		rx_data <= d;
	endtask : step
	task automatic ed(input logic [7:0] v);
		step('{ed_done: 1'b1, ed_value: v, length: 11'h7FF, default: 1'b0}, 1'b0, ~v);
		step('{ed_value: ~v, length: 11'h000, default: 1'b0}, 1'b0, v);
	endtask : ed
	task automatic frame(input logic [10:0] n, input logic ok, input logic [7:0] d0, input logic [7:0] v);
		ftc_pkg::ftc_rx_ev_t e;
		e = '{length: ~n, ed_value: ~v, default: 1'b0};
		e.preamble = 1'b1;
		step(e, 1'b0, ~d0);
		e.preamble = 1'b0;
		step(e, 1'b0, d0);
		e.header_ok = 1'b1;
		e.addr_match = 1'b1;
		step(e, 1'b0, ~d0);
		ed(v);
		for (int i = 0; i < n; i++)
			step('{length: ~n, ed_value: ~v, default: 1'b0}, 1'b1, d0 + i[7:0]);
		step('{frame_end: 1'b1, fcs_ok: ok, length: n, ed_value: ~v, default: 1'b0}, 1'b0, ~d0);
		step('{length: ~n, ed_value: v, default: 1'b0}, 1'b0, d0);
	endtask : frame
endmodule : ftc_radio_model

/* verif/tb_frame_txrx_ccatx_control.sv */
`timescale 1ns/1ps
`include "ftc_map.svh"
module tb_frame_txrx_ccatx_control;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_d = 1'b0;
	logic [7:0] reg_rdata, rx_data, fcs_cnt, v, n;
	logic rx_data_valid, pa_on, analog_supply, agc_hold, baseband_enable, ed_start;
	ftc_pkg::ftc_rx_ev_t rx_ev;
	ftc_pkg::ftc_tx_oct_t tx_oct;
	logic [31:0] seed = 32'h0000662F;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] exp_q[$];
	logic [7:0] tx_q[$];
	always #4 core_clk = ~core_clk;
	ftc_frame_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_ev(rx_ev), .rx_data(rx_data),
		.rx_data_valid(rx_data_valid), .tx_oct(tx_oct), .pa_on(pa_on), .analog_supply(analog_supply),
		.agc_hold(agc_hold), .baseband_enable(baseband_enable), .ed_start(ed_start));
	ftc_radio_model radio (.core_clk(core_clk), .nrst(nrst), .tx_oct(tx_oct), .rx_ev(rx_ev),
		.rx_data(rx_data), .rx_data_valid(rx_data_valid), .fcs_cnt(fcs_cnt));
	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task conclude();
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : rd
	// payload of 1 to 6 octets, length counts two checksum octets
	task txload();
		n = rnd() % 8'h06 + 8'h01;
		wr(`FTC_A_TXLL, n + 8'h02);
		wr(`FTC_A_TXLH, 8'h00);
		for (int i = 0; i < n; i++)
		begin
			v = rnd();
			tx_q.push_back(v);
			wr(`FTC_A_TXBUF, v);
		end
	endtask : txload
	always @(posedge core_clk)
	begin
		rd_d <= reg_rd;
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			conclude();
		end
	end
	always @(negedge core_clk)
	begin
		if (rd_d)
			chk(reg_rdata, exp_q.pop_front());
		if (tx_oct.valid === 1'b1 && tx_oct.fcs === 1'b0)
			chk(tx_oct.data, tx_q.pop_front());
	end
	initial
	begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		rd(`FTC_A_CTRL, `FTC_CTRL_RST);
		rd(8'hFF, 8'h00);
		wr(`FTC_A_CMD, {5'h00, `FTC_CMD_TX});
		rd(`FTC_A_STATE, {5'h00, ftc_pkg::ST_OFF});
		wr(`FTC_A_CMD, {5'h00, `FTC_CMD_PREP});
		repeat (20) @(posedge core_clk);
		rd(`FTC_A_IRQS, 8'h01);
		rd(`FTC_A_STATE, {5'h00, ftc_pkg::ST_PREP});
		wr(`FTC_A_CTRL, 8'h07);
		txload();
		wr(`FTC_A_CMD, {5'h00, `FTC_CMD_TX});
		repeat (n + 25) @(posedge core_clk);
		rd(`FTC_A_IRQS, 8'h03);
		rd(`FTC_A_STATE, {5'h00, ftc_pkg::ST_PREP});
		chk(fcs_cnt, 8'h02);
		wr(`FTC_A_CMD, {5'h00, `FTC_CMD_RX});
		rd(`FTC_A_STATE, {5'h00, ftc_pkg::ST_RX});
		radio.frame(11'h000, 1'b0, 8'h5A, 8'h11);
		rd(`FTC_A_STATE, {5'h00, ftc_pkg::ST_RX});
		rd(`FTC_A_IRQS, 8'h24);
		wr(`FTC_A_CTRL, 8'h0F);
		v = rnd();
		radio.frame(11'h003, 1'b1, v, ~v);
		rd(`FTC_A_IRQS, 8'h3D);
		rd(`FTC_A_STATE, {5'h00, ftc_pkg::ST_PREP});
		rd(`FTC_A_RXLL, 8'h03);
		rd(`FTC_A_RXLH, 8'h00);
		rd(`FTC_A_EDV, ~v);
		for (int i = 0; i < 3; i++)
			rd(`FTC_A_RXBS, v + i[7:0]);
		wr(`FTC_A_THR, 8'hAC);
		wr(`FTC_A_AMCS, 8'h01);
		// first an idle channel, then a reading equal to the threshold
		for (int k = 0; k < 2; k++)
		begin
			wr(`FTC_A_CTRL, 8'h06);
			wr(`FTC_A_CMD, {5'h00, `FTC_CMD_RX});
			if (k == 0)
				txload();
			wr(`FTC_A_EDC, 8'h01);
			radio.ed(k ? 8'hAC : rnd() % 8'hAC);
			repeat (n + 25) @(posedge core_clk);
			rd(`FTC_A_IRQS, k ? 8'h22 : 8'h23);
			rd(`FTC_A_AMCS, k ? 8'h09 : 8'h01);
			rd(`FTC_A_STATE, k ? {5'h00, ftc_pkg::ST_RX} : {5'h00, ftc_pkg::ST_PREP});
		end
		chk(fcs_cnt, 8'h04);
		repeat (2) @(posedge core_clk);
		conclude();
	end
endmodule : tb_frame_txrx_ccatx_control
